// ==== common/mul_interlock_defines.vh ====
// Overview of operation
// - Accumulator load from register after multiply gets access stage.
// - Its access stage stretches over remaining busy cycles as one slot.
// - Stretched access contends with instruction fetch like any multiplier access.
// - Accumulator load from memory after multiply is handled alike.
// - Word multiply: fetch, decode, operate, access, two busy cycles.
// - Multiplier stays busy exactly two cycles after the access ends.
// - Multiply access meeting fetch splits the slot; fetch goes next.
// - A non-multiplier follower runs normally; busy cycles never stall.
// - Flag multiplier users that directly follow a word multiply.
`ifndef MUL_INTERLOCK_DEFINES_VH
`define MUL_INTERLOCK_DEFINES_VH

// ****************************************************
// Instruction classes seen by the interlock
// ****************************************************
`define CLS_W              4
`define CLS_NONE           4'h0
`define CLS_SIGNED_MUL     4'h1
`define CLS_UNSIGNED_MUL   4'h2
`define CLS_LDACC_REG      4'h3
`define CLS_LDACC_MEM      4'h4
`define CLS_STACC_REG      4'h5
`define CLS_STACC_MEM      4'h6
`define CLS_MAC_WORD       4'h7
`define CLS_MAC_LONG       4'h8
`define CLS_DOUBLE_MUL     4'h9

// ****************************************************
// Multiplier timing
// ****************************************************
`define BUSY_W             2
`define BUSY_CYCLES        2'h2
`define BUSY_LAST          2'h1
`define BUSY_IDLE          2'h0

`endif

// ==== hw/busy_counter.v ====
`timescale 1ns/1ps
// ****************************************************
// Reloadable down counter of remaining busy cycles
// ****************************************************
module busy_counter #(
   parameter W = 2
) (
   // Clock and reset
   input  wire         clk_i,
   input  wire         rst_i,
   // Control
   input  wire         load_i,
   input  wire [W-1:0] value_i,
   // Count
   output wire [W-1:0] count_o
);

   reg [W-1:0] count_r;
   reg [W-1:0] count_nxt;

   always @* begin
      count_nxt = count_r;
      if (load_i) begin
         count_nxt = value_i;
      end else if (count_r != {W{1'b0}}) begin
         count_nxt = count_r - {{(W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         count_r <= {W{1'b0}};
      end else begin
         count_r <= count_nxt;
      end
   end

   assign count_o = count_r;

endmodule // busy_counter

// ==== hw/multiplier_pipeline_interlock.v ====
`timescale 1ns/1ps
`include "mul_interlock_defines.vh"

module multiplier_pipeline_interlock (
   // Clock and reset
   input  wire                 clk_i,
   input  wire                 rst_i,
   // Decode stage
   input  wire                 dec_valid_i,
   input  wire [`CLS_W-1:0]    dec_cls_i,
   output wire                 dec_accept_o,
   // Instruction fetch arbitration
   input  wire                 fetch_req_i,
   output wire                 fetch_grant_o,
   output wire                 hold_o,
   // Multiplier status
   output wire                 mult_access_o,
   output wire                 access_stretch_o,
   output wire                 access_done_o,
   output wire                 mult_busy_o,
   output reg                  contention_o
);

   // ****************************************************
   // Class helpers
   // ****************************************************
   function is_word_mul;
      input [`CLS_W-1:0] c;
      begin
         is_word_mul = (c == `CLS_SIGNED_MUL) ||
                       (c == `CLS_UNSIGNED_MUL);
      end
   endfunction

   function is_acc_load;
      input [`CLS_W-1:0] c;
      begin
         is_acc_load = (c == `CLS_LDACC_REG) ||
                       (c == `CLS_LDACC_MEM);
      end
   endfunction

   // Every class except plain instructions reaches the multiplier
   function uses_mult;
      input [`CLS_W-1:0] c;
      begin
         uses_mult = (c != `CLS_NONE) && (c <= `CLS_DOUBLE_MUL);
      end
   endfunction

   // ****************************************************
   // Stage registers
   // ****************************************************
   reg                 op_valid_r;
   reg  [`CLS_W-1:0]   op_cls_r;
   reg                 acc_valid_r;
   reg  [`CLS_W-1:0]   acc_cls_r;
   reg                 acc_follow_r;
   reg  [`CLS_W-1:0]   last_cls_r;

   reg                 op_valid_nxt;
   reg  [`CLS_W-1:0]   op_cls_nxt;
   reg                 acc_valid_nxt;
   reg  [`CLS_W-1:0]   acc_cls_nxt;
   reg                 acc_follow_nxt;
   reg  [`CLS_W-1:0]   last_cls_nxt;
   reg                 contention_nxt;

   wire [`BUSY_W-1:0]  busy_cnt;
   wire                acc_mult;
   wire                stretch;
   wire                acc_done;
   wire                split_now;
   wire                hold;
   wire                busy_load;
   wire                advance;
   wire                acc_is_mul;
   wire                op_uses;
   wire                last_is_mul;

   // ****************************************************
   // Decoded class flags
   // ****************************************************
   // Decoded once so every stage sees the same class view
   assign advance     = !hold;
   assign acc_is_mul  = is_word_mul(acc_cls_r);
   assign op_uses     = uses_mult(op_cls_r);
   assign last_is_mul = is_word_mul(last_cls_r);

   // ****************************************************
   // Access stage control
   // ****************************************************
   // Only multiplier users take part in the port arbitration
   assign acc_mult = acc_valid_r && uses_mult(acc_cls_r);

   // Accumulator load right after a multiply waits for the last
   // busy cycle; it then finishes together with it
   // Other multiplier users are only flagged, not held: the
   // stretch covers accumulator loads alone
   assign stretch = acc_valid_r && acc_follow_r &&
                    is_acc_load(acc_cls_r) &&
                    (busy_cnt > `BUSY_LAST);

   assign acc_done = acc_valid_r && !stretch;

   // Fetch loses the port to the access, then gets the second half
   assign split_now = acc_done && acc_mult &&
                      fetch_req_i;

   assign hold = stretch || split_now;

   // Fetch is blocked for the whole (possibly stretched) access slot
   assign fetch_grant_o = fetch_req_i && !acc_mult;

   // ****************************************************
   // Outputs
   // ****************************************************
   // Busy follows the registered count, so it never glitches
   assign hold_o           = hold;
   assign dec_accept_o     = !hold;
   assign mult_access_o    = acc_mult;
   assign access_stretch_o = stretch;
   assign access_done_o    = acc_done;
   assign mult_busy_o      = (busy_cnt != `BUSY_IDLE);

   // ****************************************************
   // Multiplier busy cycles
   // ****************************************************
   // Counted from the end of the access, not from the slot, so a
   // split or a held pipeline never changes the busy length
   assign busy_load = acc_done && acc_is_mul;

   busy_counter #(
      .W (`BUSY_W)
   ) u_busy (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .load_i  (busy_load),
      .value_i (`BUSY_CYCLES),
      .count_o (busy_cnt)
   );

   // ****************************************************
   // Operate stage
   // ****************************************************
   // Held decode inputs are ignored, not queued: the decode
   // stage keeps them until accept is seen high at an edge
   always @* begin
      op_valid_nxt = op_valid_r;
      op_cls_nxt   = op_cls_r;
      if (advance) begin
         // Plain followers move on unless a split holds them; busy alone never holds
         op_valid_nxt = dec_valid_i;
         op_cls_nxt   = dec_cls_i;
      end
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         op_valid_r <= 1'b0;
         op_cls_r   <= `CLS_NONE;
      end else begin
         op_valid_r <= op_valid_nxt;
         op_cls_r   <= op_cls_nxt;
      end
   end

   // ****************************************************
   // Access stage
   // ****************************************************
   always @* begin
      acc_valid_nxt  = acc_valid_r;
      acc_cls_nxt    = acc_cls_r;
      acc_follow_nxt = acc_follow_r;
      if (advance) begin
         acc_valid_nxt  = op_valid_r;
         acc_cls_nxt    = op_cls_r;
         // Follower flag keeps adjacency across bubbles
         acc_follow_nxt = op_valid_r && last_is_mul;
      end else if (acc_done) begin
         // Split: access is finished, leave a bubble for the fetch
         acc_valid_nxt = 1'b0;
      end
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         acc_valid_r  <= 1'b0;
         acc_cls_r    <= `CLS_NONE;
         acc_follow_r <= 1'b0;
      end else begin
         acc_valid_r  <= acc_valid_nxt;
         acc_cls_r    <= acc_cls_nxt;
         acc_follow_r <= acc_follow_nxt;
      end
   end

   // ****************************************************
   // Instruction history and contention flag
   // ****************************************************
   // Bubbles do not break adjacency: only a valid instruction
   // replaces the remembered class, and a held one never flags
   // twice, so the flag marks its first access cycle only
   always @* begin
      last_cls_nxt   = last_cls_r;
      contention_nxt = 1'b0;
      if (advance && op_valid_r) begin
         last_cls_nxt   = op_cls_r;
         contention_nxt = last_is_mul && op_uses;
      end
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         last_cls_r   <= `CLS_NONE;
         contention_o <= 1'b0;
      end else begin
         last_cls_r   <= last_cls_nxt;
         contention_o <= contention_nxt;
      end
   end

endmodule // multiplier_pipeline_interlock

// ==== bench/mul_interlock_checker.sv ====
`timescale 1ns/1ps
// ****************************************************
// Port checks for the multiplier interlock
// ****************************************************
module mul_interlock_checker (
   input wire       clk_i,
   input wire       rst_i,
   input wire       dec_valid_i,
   input wire [3:0] dec_cls_i,
   input wire       dec_accept_o,
   input wire       fetch_req_i,
   input wire       fetch_grant_o,
   input wire       hold_o,
   input wire       mult_access_o,
   input wire       access_stretch_o,
   input wire       access_done_o,
   input wire       mult_busy_o,
   input wire       contention_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_accept_hold: assert property (dec_accept_o == !hold_o)
      else $error("accept is not the inverse of hold");
   a_grant_rule: assert property (fetch_grant_o ==
      (fetch_req_i && !mult_access_o)) else $error("grant wrong");
   a_busy_two: assert property ($rose(mult_busy_o) |->
      mult_busy_o[*2]) else $error("busy shorter than two cycles");
   a_stretch_hold: assert property (access_stretch_o |->
      hold_o && mult_busy_o) else $error("stretch without hold");
   a_stretch_fetch: assert property (access_stretch_o |->
      mult_access_o && !fetch_grant_o) else $error("fetch during stretch");
   a_stretch_ends: assert property (access_stretch_o |->
      ##[1:2] !access_stretch_o) else $error("stretch too long");
   a_stretch_done: assert property ($fell(access_stretch_o) |->
      access_done_o) else $error("stretch ended without done");
   a_contend_pulse: assert property (contention_o && hold_o |=>
      !contention_o) else $error("contention repeated while held");
   a_contend_access: assert property (contention_o |->
      mult_access_o) else $error("contention outside access");
   a_split_next: assert property (
      mult_access_o && access_done_o && fetch_req_i |=> !mult_access_o)
      else $error("split slot not freed");
   c_stretch: cover property (access_stretch_o);
   c_contend: cover property (contention_o);
   c_split: cover property (mult_access_o && fetch_req_i);
endmodule // mul_interlock_checker

bind multiplier_pipeline_interlock mul_interlock_checker u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .dec_valid_i(dec_valid_i),
   .dec_cls_i(dec_cls_i), .dec_accept_o(dec_accept_o),
   .fetch_req_i(fetch_req_i), .fetch_grant_o(fetch_grant_o),
   .hold_o(hold_o), .mult_access_o(mult_access_o),
   .access_stretch_o(access_stretch_o), .access_done_o(access_done_o),
   .mult_busy_o(mult_busy_o), .contention_o(contention_o));

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       dec_valid_i = 1'b0;
   logic [3:0] dec_cls_i = 4'h0;
   logic       fetch_req_i = 1'b0;
   wire        dec_accept_o, fetch_grant_o, hold_o, mult_access_o;
   wire        access_stretch_o, access_done_o, mult_busy_o, contention_o;
   int         n_fail = 0;
   int         cmp_count = 0;

   initial forever #10 clk_i = ~clk_i;

   multiplier_pipeline_interlock u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .dec_valid_i(dec_valid_i), .dec_cls_i(dec_cls_i),
      .dec_accept_o(dec_accept_o), .fetch_req_i(fetch_req_i),
      .fetch_grant_o(fetch_grant_o), .hold_o(hold_o),
      .mult_access_o(mult_access_o), .access_stretch_o(access_stretch_o),
      .access_done_o(access_done_o), .mult_busy_o(mult_busy_o),
      .contention_o(contention_o));

   // ****************************************************
   // Helpers
   // ****************************************************
   task chk(input string nm, input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask

   task wrap_up;
      if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Multiply then follower; returns mid-cycle of the multiply access
   task issue(input logic [3:0] a, input logic [3:0] b, input logic f);
      @(posedge clk_i);
      dec_valid_i <= 1'b1;
      dec_cls_i   <= a;
      fetch_req_i <= f;
      @(posedge clk_i);
      dec_cls_i   <= b;
      @(posedge clk_i);
      dec_valid_i <= 1'b0;
      @(negedge clk_i);
   endtask

   // ****************************************************
   // Scenarios
   // ****************************************************
   task s_follow(input logic [3:0] s);
      logic st;
      logic ct;
      st = (s == 4'h3 || s == 4'h4);
      ct = (s != 4'h0 && s < 4'hA);
      issue(s[0] ? 4'h1 : 4'h2, s, 1'b0);
      chk("mul_access", 1'b1, mult_access_o);
      // Fetch asks only once the follower owns the access stage
      @(posedge clk_i);
      fetch_req_i <= st;
      @(negedge clk_i);
      chk("contention", ct, contention_o);
      chk("fol_access", ct, mult_access_o);
      chk("stretch", st, access_stretch_o);
      chk("hold3", st, hold_o);
      chk("accept3", !st, dec_accept_o);
      chk("grant3", 1'b0, fetch_grant_o);
      chk("busy3", 1'b1, mult_busy_o);
      @(negedge clk_i);
      chk("done4", st, access_done_o);
      chk("grant4", 1'b0, fetch_grant_o);
      chk("hold4", st, hold_o);
      chk("busy4", 1'b1, mult_busy_o);
      @(negedge clk_i);
      chk("grant5", st, fetch_grant_o);
      chk("hold5", 1'b0, hold_o);
      if (s < 4'h7)
         chk("busy5", s == 4'h1 || s == 4'h2, mult_busy_o);
      @(posedge clk_i);
      fetch_req_i <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask

   // Reset in mid-multiply must empty every stage at once
   task s_reset;
      issue(4'h2, 4'h3, 1'b0);
      chk("rst_pre", 1'b1, mult_access_o);
      @(posedge clk_i);
      rst_i <= 1'b1;
      @(negedge clk_i);
      chk("rst_access", 1'b0, mult_access_o);
      chk("rst_busy", 1'b0, mult_busy_o);
      chk("rst_hold", 1'b0, hold_o);
      chk("rst_contend", 1'b0, contention_o);
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk("rst_accept", 1'b1, dec_accept_o);
      chk("rst_stretch", 1'b0, access_stretch_o);
      repeat (2) @(posedge clk_i);
   endtask

   task s_split;
      issue(4'h1, 4'h0, 1'b1);
      chk("split_grant", 1'b0, fetch_grant_o);
      chk("split_hold", 1'b1, hold_o);
      chk("split_done", 1'b1, access_done_o);
      @(negedge clk_i);
      chk("split_next", 1'b1, fetch_grant_o);
      chk("split_free", 1'b0, mult_access_o);
      @(posedge clk_i);
      fetch_req_i <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask

   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int s = 0; s < 11; s++) s_follow(s[3:0]);
      s_reset();
      s_split();
      wrap_up();
   end
endmodule // tb_top
